// file: tmr_pkg.sv
// constants, register map and field layouts of the 8-bit timer/counter
package tmr_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] TMR_OFS_CONTROL = 8'h00; // timer_control_register
  localparam logic [7:0] TMR_OFS_COUNT = 8'h04;   // count_value
  localparam logic [7:0] TMR_OFS_COMPARE = 8'h08; // compare_value
  localparam logic [7:0] TMR_OFS_FLAG = 8'h0C;    // timer_flag_register
  localparam logic [7:0] TMR_OFS_MASK = 8'h10;    // timer_mask_register
  localparam logic [7:0] TMR_OFS_ASYNC = 8'h14;   // async_status_register

  // bit positions inside the flag, mask and async status registers
  localparam int TMR_BIT_CMP = 7; // compare_flag / compare_irq_enable
  localparam int TMR_BIT_OVF = 6; // overflow_flag / overflow irq enable
  localparam int TMR_BIT_ASYNC = 0; // async_clock_select

  // counter landmarks
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_MAX = 8'hFF;

  // reset values
  localparam logic [7:0] TMR_RST_BYTE = 8'h00;

  // bus answers
  localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;

  // waveform modes, encoded as the two waveform_mode_field bits
  localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMR_WGM_PHASE = 2'h1;
  localparam logic [1:0] TMR_WGM_CTC = 2'h2;
  localparam logic [1:0] TMR_WGM_FAST = 2'h3;

  // compare_output_mode actions for non-PWM modes
  localparam logic [1:0] TMR_COM_NONE = 2'h0;
  localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR_COM_SET = 2'h3;

  // timer_control_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic force_compare_strobe;       // write-only, reads zero
    logic [1:0] compare_output_mode;
    logic [1:0] waveform_mode_field;  // [1] high, [0] low
    logic [2:0] clock_select_field;
  } tmr_ctrl_t;

  // decoded register index
  typedef enum logic [2:0] {
    TMR_REG_CONTROL, TMR_REG_COUNT, TMR_REG_COMPARE,
    TMR_REG_FLAG, TMR_REG_MASK, TMR_REG_ASYNC, TMR_REG_NONE
  } tmr_reg_t;

endpackage : tmr_pkg

// file: tmr_timer8.sv
// 8-bit timer/counter with one compare channel behind an AXI4-Lite slave
//
// Function
// - count and compare are 8-bit software registers
// - clock select zero stops the counter
// - async select switches source to crystal
// - crystal edges sampled on the I/O clock
// - count readable and writable while stopped
// - software count write beats counter update
// - each tick clears, increments or decrements
// - BOTTOM 0x00, MAX 0xFF, TOP mode dependent
// - overflow flag set per waveform mode
// - match sets compare flag next tick
// - enabled compare flag raises interrupt request
// - compare flag clears on service or write-one
// - flags and masks in shared registers
// - waveform from match, mode, MAX, BOTTOM
// - compare double buffered only in PWM
// - compare access hits buffer when buffered
// - force strobe acts like match in non-PWM modes, no flag
// - count write blocks next tick's match
// - output register kept across mode change
// - output mode change acts immediately
// - normal mode wraps, overflow at zero
// - clear-on-match mode clears at compare
// - fast PWM single slope, set/clear output
// - output mode zero means no action
`timescale 1ns/10ps
`default_nettype none

module tmr_timer8 (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // crystal oscillator pins
  input wire logic crystal_pin_in,
  output logic crystal_pin_out,
  // waveform and interrupt requests
  output logic compare_output,
  output logic compare_irq,
  output logic overflow_irq,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack
);

  // address decode, shared by the read and write paths
  function automatic tmr_pkg::tmr_reg_t decode(input logic [7:0] addr);
    unique case (addr)
      tmr_pkg::TMR_OFS_CONTROL: decode = tmr_pkg::TMR_REG_CONTROL;
      tmr_pkg::TMR_OFS_COUNT: decode = tmr_pkg::TMR_REG_COUNT;
      tmr_pkg::TMR_OFS_COMPARE: decode = tmr_pkg::TMR_REG_COMPARE;
      tmr_pkg::TMR_OFS_FLAG: decode = tmr_pkg::TMR_REG_FLAG;
      tmr_pkg::TMR_OFS_MASK: decode = tmr_pkg::TMR_REG_MASK;
      tmr_pkg::TMR_OFS_ASYNC: decode = tmr_pkg::TMR_REG_ASYNC;
      default: decode = tmr_pkg::TMR_REG_NONE;
    endcase
  endfunction : decode

  // prescaler tap for each clock select code: /1,/8,/32,/64,/128,/256,/1024
  function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] pre);
    unique case (cs)
      3'h1: tap_hit = 1'b1;
      3'h2: tap_hit = &pre[2:0];
      3'h3: tap_hit = &pre[4:0];
      3'h4: tap_hit = &pre[5:0];
      3'h5: tap_hit = &pre[6:0];
      3'h6: tap_hit = &pre[7:0];
      3'h7: tap_hit = &pre[9:0];
      default: tap_hit = 1'b0;
    endcase
  endfunction : tap_hit

  // compare_output after a match-like event, non-PWM modes
  function automatic logic com_action(input logic [1:0] com, input logic oc);
    unique case (com)
      tmr_pkg::TMR_COM_TOGGLE: com_action = ~oc;
      tmr_pkg::TMR_COM_CLEAR: com_action = 1'b0;
      tmr_pkg::TMR_COM_SET: com_action = 1'b1;
      default: com_action = oc; // mode zero: no action
    endcase
  endfunction : com_action

  // software-visible state
  tmr_pkg::tmr_ctrl_t ctrl;   // force bit is never stored
  logic [7:0] count_value;
  logic [7:0] compare_buf;    // buffer written by software in PWM modes
  logic [7:0] compare_act;    // value the comparator uses
  logic compare_flag;
  logic overflow_flag;
  logic compare_irq_enable;
  logic overflow_irq_enable;
  logic async_clock_select;

  // counter engine state
  logic [9:0] prescale;       // shared divider for all taps
  logic count_up;             // direction in phase-correct mode
  logic block_match;          // armed by a count write until the next tick
  logic xtal_s1, xtal_s2, xtal_s3; // crystal synchroniser and edge history

  // bus slave state
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // crystal input crosses into aclk through two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      crystal_pin_out <= 1'b1;
    end else begin
      xtal_s1 <= crystal_pin_in;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      crystal_pin_out <= ~xtal_s2; // inverting amplifier feedback
    end
  end

  // source edge: every io_clock cycle, or a crystal rising edge
  logic src_tick;
  assign src_tick = async_clock_select ? (xtal_s2 & ~xtal_s3) : 1'b1;

  // timer_clock tick; a zero clock select gives none at all
  logic tick;
  assign tick = src_tick & tap_hit(ctrl.clock_select_field, prescale);

  // landmark and mode decode
  logic is_bottom, is_max, pwm_mode, raw_match, match;
  assign is_bottom = (count_value == tmr_pkg::TMR_BOTTOM);
  assign is_max = (count_value == tmr_pkg::TMR_MAX);
  assign pwm_mode = ctrl.waveform_mode_field[0]; // modes 1 and 3 are PWM
  assign raw_match = (count_value == compare_act);
  assign match = raw_match & ~block_match;

  // write fires once both address and data are held and no answer is out
  logic wr_fire;
  tmr_pkg::tmr_reg_t wr_reg;
  logic wr_lo;
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_reg = decode(wr_addr);
  assign wr_lo = wr_strb[0]; // all fields live in byte lane 0

  logic wr_count, wr_compare, wr_ctrl, force_now;
  assign wr_count = wr_fire & wr_lo & (wr_reg == tmr_pkg::TMR_REG_COUNT);
  assign wr_compare = wr_fire & wr_lo & (wr_reg == tmr_pkg::TMR_REG_COMPARE);
  assign wr_ctrl = wr_fire & wr_lo & (wr_reg == tmr_pkg::TMR_REG_CONTROL);
  // force only counts in non-PWM modes, judged on the mode being written
  assign force_now = wr_ctrl & wr_data[7] & ~wr_data[3];

  // AXI write channels: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tmr_pkg::TMR_RESP_OKAY;
      wr_addr <= tmr_pkg::TMR_RST_BYTE;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      // response follows both halves; unmapped offsets answer SLVERR
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_reg == tmr_pkg::TMR_REG_NONE) ? tmr_pkg::TMR_RESP_SLVERR
                                                         : tmr_pkg::TMR_RESP_OKAY;
      end
      // both channels reopen only after the answer is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read mux; buffered compare is what software sees in PWM modes
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (decode(s_axi_araddr))
      tmr_pkg::TMR_REG_CONTROL: rd_word[7:0] = {1'b0, ctrl[6:0]}; // force reads zero
      tmr_pkg::TMR_REG_COUNT: rd_word[7:0] = count_value;
      tmr_pkg::TMR_REG_COMPARE: rd_word[7:0] = pwm_mode ? compare_buf : compare_act;
      tmr_pkg::TMR_REG_FLAG: begin
        rd_word[tmr_pkg::TMR_BIT_CMP] = compare_flag;
        rd_word[tmr_pkg::TMR_BIT_OVF] = overflow_flag;
      end
      tmr_pkg::TMR_REG_MASK: begin
        rd_word[tmr_pkg::TMR_BIT_CMP] = compare_irq_enable;
        rd_word[tmr_pkg::TMR_BIT_OVF] = overflow_irq_enable;
      end
      tmr_pkg::TMR_REG_ASYNC: rd_word[tmr_pkg::TMR_BIT_ASYNC] = async_clock_select;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // AXI read channel: one outstanding read, answered the next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tmr_pkg::TMR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (decode(s_axi_araddr) == tmr_pkg::TMR_REG_NONE) ? tmr_pkg::TMR_RESP_SLVERR
                                                                     : tmr_pkg::TMR_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control, mask and async select: plain software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= tmr_pkg::tmr_ctrl_t'(tmr_pkg::TMR_RST_BYTE);
      compare_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
      async_clock_select <= 1'b0; // io_clock after reset
    end else if (wr_fire && wr_lo) begin
      // output mode bits are not buffered: they act from the next cycle
      if (wr_reg == tmr_pkg::TMR_REG_CONTROL) begin
        ctrl <= tmr_pkg::tmr_ctrl_t'({1'b0, wr_data[6:0]});
      end
      if (wr_reg == tmr_pkg::TMR_REG_MASK) begin
        compare_irq_enable <= wr_data[tmr_pkg::TMR_BIT_CMP];
        overflow_irq_enable <= wr_data[tmr_pkg::TMR_BIT_OVF];
      end
      if (wr_reg == tmr_pkg::TMR_REG_ASYNC) begin
        async_clock_select <= wr_data[tmr_pkg::TMR_BIT_ASYNC];
      end
    end
  end

  // prescaler runs on source edges only while a clock is selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 10'h000;
    end else if (ctrl.clock_select_field == 3'h0) begin
      prescale <= 10'h000;
    end else if (src_tick) begin
      prescale <= prescale + 10'h001;
    end
  end

  // counter sequence and direction per waveform mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= tmr_pkg::TMR_RST_BYTE;
      count_up <= 1'b1;
    end else if (wr_count) begin
      count_value <= wr_data[7:0]; // software write beats the tick
    end else if (tick) begin
      unique case (ctrl.waveform_mode_field)
        tmr_pkg::TMR_WGM_CTC: begin
          count_value <= match ? tmr_pkg::TMR_BOTTOM : count_value + 8'h01;
          count_up <= 1'b1;
        end
        tmr_pkg::TMR_WGM_PHASE: begin
          if (count_up && is_max) begin
            count_up <= 1'b0;
            count_value <= count_value - 8'h01;
          end else if (!count_up && is_bottom) begin
            count_up <= 1'b1;
            count_value <= count_value + 8'h01;
          end else begin
            count_value <= count_up ? count_value + 8'h01 : count_value - 8'h01;
          end
        end
        default: begin // normal and fast PWM: single slope, wrap MAX to BOTTOM
          count_value <= count_value + 8'h01;
          count_up <= 1'b1;
        end
      endcase
    end
  end

  // a count write arms the blocker; it stays armed while stopped until the next tick consumes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // compare register pair; buffer loads active at TOP in PWM modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_buf <= tmr_pkg::TMR_RST_BYTE;
      compare_act <= tmr_pkg::TMR_RST_BYTE;
    end else begin
      if (wr_compare) begin
        compare_buf <= wr_data[7:0];
        if (!pwm_mode) begin
          compare_act <= wr_data[7:0]; // direct access, no buffering
        end
      end
      // update at MAX, the turn point of both PWM sequences
      if (pwm_mode && tick && is_max && !(ctrl.waveform_mode_field == tmr_pkg::TMR_WGM_PHASE && !count_up)) begin
        compare_act <= compare_buf;
      end
    end
  end

  // overflow event per mode
  logic ovf_event;
  always_comb begin
    unique case (ctrl.waveform_mode_field)
      tmr_pkg::TMR_WGM_PHASE: ovf_event = tick & ~count_up & is_bottom;
      tmr_pkg::TMR_WGM_CTC: ovf_event = tick & is_max & ~match;
      default: ovf_event = tick & is_max; // count becomes BOTTOM next
    endcase
  end

  // sticky flags: hardware set wins over service or write-one clear
  logic clr_cmp, clr_ovf, set_cmp;
  assign clr_cmp = compare_irq_ack
                 | (wr_fire & wr_lo & (wr_reg == tmr_pkg::TMR_REG_FLAG) & wr_data[tmr_pkg::TMR_BIT_CMP]);
  assign clr_ovf = overflow_irq_ack
                 | (wr_fire & wr_lo & (wr_reg == tmr_pkg::TMR_REG_FLAG) & wr_data[tmr_pkg::TMR_BIT_OVF]);
  assign set_cmp = tick & match;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_flag <= 1'b0;
    end else if (set_cmp) begin
      compare_flag <= 1'b1;
    end else if (clr_cmp) begin
      compare_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else if (ovf_event) begin
      overflow_flag <= 1'b1;
    end else if (clr_ovf) begin
      overflow_flag <= 1'b0;
    end
  end

  // interrupt requests follow the gated flags one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      compare_irq <= compare_flag & compare_irq_enable;
      overflow_irq <= overflow_flag & overflow_irq_enable;
    end
  end

  // waveform generator; the output register is never reset by a mode change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output <= 1'b0;
    end else if (force_now) begin
      compare_output <= com_action(wr_data[6:5], compare_output);
    end else if (tick) begin
      unique case (ctrl.waveform_mode_field)
        tmr_pkg::TMR_WGM_FAST: begin
          if (ctrl.compare_output_mode[1] && match) begin
            compare_output <= ctrl.compare_output_mode[0];
          end else if (ctrl.compare_output_mode[1] && is_max) begin
            compare_output <= ~ctrl.compare_output_mode[0]; // value at BOTTOM
          end
        end
        tmr_pkg::TMR_WGM_PHASE: begin
          if (ctrl.compare_output_mode[1] && match) begin
            compare_output <= count_up ? ctrl.compare_output_mode[0] : ~ctrl.compare_output_mode[0];
          end
        end
        default: begin
          if (match) begin
            compare_output <= com_action(ctrl.compare_output_mode, compare_output);
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence

  a_stop_holds: assert property ((ctrl.clock_select_field == 3'h0) && !wr_count |=> $stable(count_value))
    else $error("counter moved while stopped");
  a_write_wins: assert property (wr_count |=> count_value == $past(wr_data[7:0]))
    else $error("count write lost");
  a_match_flag: assert property (tick && raw_match && !block_match |=> compare_flag)
    else $error("match did not set compare flag");
  a_match_blocked: assert property (tick && block_match && !compare_flag |=> !compare_flag)
    else $error("blocked match set compare flag");
  a_irq_gate: assert property (compare_flag && compare_irq_enable ##1 compare_flag |-> compare_irq)
    else $error("compare interrupt not raised");
  a_flag_clear: assert property (clr_cmp && !set_cmp |=> !compare_flag)
    else $error("compare flag not cleared");
  a_normal_wrap: assert property (tick && !wr_count && is_max && ctrl.waveform_mode_field == tmr_pkg::TMR_WGM_NORMAL
                                  |=> is_bottom && overflow_flag)
    else $error("normal mode wrap wrong");
  a_ctc_clear: assert property (tick && !wr_count && match && ctrl.waveform_mode_field == tmr_pkg::TMR_WGM_CTC
                                |=> is_bottom)
    else $error("clear on match missed");
  a_buffer_hold: assert property (pwm_mode && !(tick && is_max) |=> $stable(compare_act))
    else $error("active compare changed outside TOP");
  a_force_noflag: assert property (force_now && !set_cmp && !compare_flag |=> !compare_flag)
    else $error("force strobe set compare flag");
  a_write_answer: assert property (s_aw_taken ##0 s_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");

endmodule : tmr_timer8

`default_nettype wire

// file: tmr_timer8_test.sv
// self-checking bench for the 8-bit timer/counter, driven over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module tmr_timer8_test;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF; // all lanes, only lane 0 carries a register
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic crystal_pin_in = 1'b0, crystal_pin_out, compare_output, compare_irq, overflow_irq;
  logic compare_irq_ack = 1'b0, overflow_irq_ack = 1'b0;
  logic [31:0] rdat; // last read word
  logic [1:0] rrsp; // last read response
  int miscompares = 0, comparisons = 0;
  tmr_timer8 tmr_timer8_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .crystal_pin_in(crystal_pin_in), .crystal_pin_out(crystal_pin_out),
    .compare_output(compare_output), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
    .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack));
  // 125 MHz bus clock
  always #4 aclk = ~aclk;
  task print_verdict;
    $display("checks=%0d errors=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // address and data offered together, each dropped once taken; bready held until bvalid
  task wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk); // idle edge, so a following call never re-raises bready in this time step
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk); // idle edge between reads as well
  endtask : rd
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(rdat, {24'h000000, exp});
  endtask : rchk
  // control byte: force, output mode, waveform mode, clock select
  function automatic logic [7:0] ctl(logic f, logic [1:0] com, logic [1:0] wgm, logic [2:0] cs);
    return {f, com, wgm, cs};
  endfunction : ctl
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    tick(16);
    aresetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), 8'h00);
    rd(8'h18);
    check(rrsp, tmr_pkg::TMR_RESP_SLVERR);
    // stopped counter keeps a written value
    wr(tmr_pkg::TMR_OFS_COUNT, 8'h55);
    tick(20);
    rchk(tmr_pkg::TMR_OFS_COUNT, 8'h55);
    // normal mode wrap sets overflow, passing zero matches compare zero
    wr(tmr_pkg::TMR_OFS_MASK, 8'hC0);
    wr(tmr_pkg::TMR_OFS_COUNT, 8'hFD);
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b0, 2'h0, tmr_pkg::TMR_WGM_NORMAL, 3'h1));
    tick(12);
    wr(tmr_pkg::TMR_OFS_CONTROL, 8'h00);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'hC0);
    check(compare_irq, 1'b1);
    check(overflow_irq, 1'b1);
    compare_irq_ack <= 1'b1;
    overflow_irq_ack <= 1'b1;
    tick(1);
    compare_irq_ack <= 1'b0;
    overflow_irq_ack <= 1'b0;
    tick(3);
    check({compare_irq, overflow_irq}, 2'b00);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'h00);
    // count written equal to compare: the first tick's match is blocked
    wr(tmr_pkg::TMR_OFS_COMPARE, 8'h20);
    wr(tmr_pkg::TMR_OFS_COUNT, 8'h20);
    wr(tmr_pkg::TMR_OFS_CONTROL, 8'h01);
    tick(8);
    wr(tmr_pkg::TMR_OFS_CONTROL, 8'h00);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'h00);
    // clear on match keeps the count at or below compare
    wr(tmr_pkg::TMR_OFS_COMPARE, 8'h03);
    wr(tmr_pkg::TMR_OFS_COUNT, 8'h00);
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b0, 2'h0, tmr_pkg::TMR_WGM_CTC, 3'h1));
    tick(20);
    rd(tmr_pkg::TMR_OFS_COUNT);
    check(rdat <= 32'h3, 1'b1);
    wr(tmr_pkg::TMR_OFS_CONTROL, 8'h00);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'h80);
    wr(tmr_pkg::TMR_OFS_FLAG, 8'h80);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'h00);
    // force strobe sets then clears the output, without a flag
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b1, tmr_pkg::TMR_COM_SET, 2'h0, 3'h0));
    tick(2);
    check(compare_output, 1'b1);
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b0, 2'h0, tmr_pkg::TMR_WGM_CTC, 3'h0));
    tick(2);
    check(compare_output, 1'b1);
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b1, tmr_pkg::TMR_COM_CLEAR, 2'h0, 3'h0));
    tick(2);
    check(compare_output, 1'b0);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'h00);
    // crystal source: each rising crystal edge is one tick
    wr(tmr_pkg::TMR_OFS_COUNT, 8'h00);
    wr(tmr_pkg::TMR_OFS_ASYNC, 8'h01);
    wr(tmr_pkg::TMR_OFS_CONTROL, 8'h01);
    tick(10);
    rchk(tmr_pkg::TMR_OFS_COUNT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      crystal_pin_in <= 1'b1;
      tick(5);
      check(crystal_pin_out, 1'b0);
      crystal_pin_in <= 1'b0;
      tick(5);
    end
    check(crystal_pin_out, 1'b1);
    rchk(tmr_pkg::TMR_OFS_COUNT, 8'h04);
    rchk(tmr_pkg::TMR_OFS_ASYNC, 8'h01);
    // fast PWM: compare goes to the buffer, active value loads at MAX
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b0, tmr_pkg::TMR_COM_CLEAR, tmr_pkg::TMR_WGM_FAST, 3'h0));
    wr(tmr_pkg::TMR_OFS_ASYNC, 8'h00);
    wr(tmr_pkg::TMR_OFS_FLAG, 8'hC0);
    wr(tmr_pkg::TMR_OFS_COMPARE, 8'h80);
    rchk(tmr_pkg::TMR_OFS_COMPARE, 8'h80);
    wr(tmr_pkg::TMR_OFS_COUNT, 8'hF0);
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b0, tmr_pkg::TMR_COM_CLEAR, tmr_pkg::TMR_WGM_FAST, 3'h1));
    tick(20);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'h40);
    check(compare_output, 1'b1);
    tick(130);
    check(compare_output, 1'b0);
    rchk(tmr_pkg::TMR_OFS_FLAG, 8'hC0);
    wr(tmr_pkg::TMR_OFS_CONTROL, ctl(1'b0, tmr_pkg::TMR_COM_CLEAR, tmr_pkg::TMR_WGM_FAST, 3'h0));
    print_verdict();
  end
endmodule : tmr_timer8_test
`default_nettype wire
